/* core/frontend_defs.vh */
// Purpose: constants for the modem front-end host interface
// Assumes: included by bare name from core design files
// Notes: register map kept to the bits the interface logic uses
// Behaviour
// RULE_01: three-wire serial port reaches every register
// RULE_02: transaction is instruction byte plus data
// RULE_03: instruction taken at eighth rising edge
// RULE_04: write data applied at each byte end
// RULE_05: instruction top bit one means read
// RULE_06: bits six-five give one to four bytes
// RULE_07: low five bits give start address
// RULE_08: sample rising, change read data falling
// RULE_09: inputs ignored while select is high
// RULE_10: first eight bits form the instruction
// RULE_11: register zero bit six selects lsb-first
// RULE_12: msb-first mode decrements the address
// RULE_13: lsb-first mode increments the address
// RULE_14: ten-bit shared sample bus, device slave
// RULE_15: host clocks match the reference frequency
// RULE_16: take tx words when tx only enabled
// RULE_17: drive rx samples while rx enabled; code also releases the bus after the rx clock idles 64 clk_in cycles
// RULE_18: bus released when both enables low
// RULE_19: host clocks tx after enable drops
// RULE_20: per-direction twos complement and edge select
// RULE_21: programmable three-state for sample port
// RULE_22: host tx clock follows pll and interpolation
// RULE_23: register zero bit seven selects four-wire
// RULE_24: select release aborts partial transaction
`ifndef FRONTEND_DEFS_VH
`define FRONTEND_DEFS_VH
`define REG_CFG 5'h00
`define REG_PWR 5'h01
`define REG_SPARE 5'h02
`define REG_CLK 5'h03
`define REG_RXF 5'h04
`define REG_TUNE 5'h05
`define REG_GAIN 5'h06
`define REG_TXC 5'h07
`define REG_RXC 5'h08
`define REG_VER 5'h0f
`define RST_CFG 8'h00
`define RST_PWR 8'h00
`define RST_SPARE 8'h00
`define RST_CLK 8'h01
`define RST_RXF 8'h01
`define RST_TUNE 8'h80
`define RST_GAIN 8'h00
`define RST_TXC 8'h10
`define RST_RXC 8'h00
`define CFG_FOURWIRE 7
`define CFG_LSBFIRST 6
`define CFG_SWRESET 5
`define TXC_FALL 1
`define TXC_TWOS 0
`define RXC_TRISTATE 3
`define RXC_FALL 1
`define RXC_TWOS 0
`define INS_READ 7
`define INS_CNT_HI 6
`define INS_CNT_LO 5
`define SAMPLE_MSB 9
`define BIT_LAST 3'h7
`define INS_ADDR_HI 4
`define INS_ADDR_LO 0
`define RXK_IDLE_LIMIT 8'h40
`endif

/* core/sample_fifo.v */
// Purpose: synchronous fifo with valid/ready on both sides
// Assumes: single clock, width and depth as parameters
// Notes: depth must be a power of two
`timescale 1ns/10ps
module sample_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk_in, // clock
  input wire rstn_in, // async reset, active low
  input wire [WIDTH-1:0] in_data_in, // write data
  input wire in_valid_in, // write request
  output wire in_ready_out, // room available
  output wire [WIDTH-1:0] out_data_out, // head word
  output wire out_valid_out, // not empty
  input wire out_ready_in // consumer takes word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = in_valid_in && !full;
  wire pop = out_ready_in && !empty;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_q[AW-1:0]];
  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data_in;
    end
  end
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sample_fifo

/* core/frontend_host_if.v */
// Purpose: serial register port and shared sample bus of the front end
// Assumes: serial and sample clocks are pins, oversampled by clk_in
// Notes: register bits drive the sample port; analogue side sits outside
`timescale 1ns/10ps
`include "frontend_defs.vh"
module frontend_host_if #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5,
  parameter [3:0] VERSION = 4'h0 // arbitrary value
) (
  input wire clk_in, // 125 mhz system clock
  input wire rstn_in, // async reset, active low
  input wire serial_clock_in, // serial port clock pin
  input wire serial_select_n_in, // serial select, active low
  input wire serial_data_io_in, // serial data pin level
  output reg serial_data_io_out, // serial data drive value
  output reg serial_data_io_oe_out, // serial data drive enable
  output reg boost_serial_out_pin_out, // four-wire serial output
  input wire tx_enable_in, // transmit enable pin
  input wire rx_enable_in, // receive enable pin
  input wire tx_clock_in, // transmit clock pin
  input wire rx_clock_in, // receive clock pin
  input wire [9:0] shared_sample_bus_in, // sample bus pin levels
  output reg [9:0] shared_sample_bus_out, // sample bus drive value
  output reg shared_sample_bus_oe_out, // sample bus drive enable
  output wire [9:0] tx_word_out, // transmit word to datapath
  output wire tx_word_valid_out, // transmit word present
  input wire tx_word_ready_in, // datapath takes transmit word
  input wire [9:0] rx_sample_in, // adc sample, straight binary
  output wire [7:0] pwr_reg_out, // power-down register
  output wire [7:0] clk_reg_out, // clock source register
  output wire [7:0] rxf_reg_out, // receive filter register
  output wire [7:0] tune_reg_out, // filter tuning register
  output wire [7:0] gain_reg_out, // gain register
  output wire [7:0] txc_reg_out, // transmit config register
  output wire [7:0] rxc_reg_out, // receive config register
  output wire soft_reset_out, // software reset pulse
  output wire fifo_overflow_out // tx word lost, fifo full
);
  // state codes
  localparam ST_INS = 2'h0;
  localparam ST_DATA = 2'h1;
  localparam ST_DONE = 2'h2;

  function [7:0] rev8;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        rev8[i] = v[7-i];
      end
    end
  endfunction

  // twos complement and straight binary differ only in the sign bit
  function [9:0] fmt_flip;
    input [9:0] w;
    input twos;
    begin
      fmt_flip = {w[`SAMPLE_MSB] ^ twos, w[`SAMPLE_MSB-1:0]};
    end
  endfunction

  // two-flop synchronisers for every pin input
  reg [1:0] sck_s_q;
  reg [1:0] sel_s_q;
  reg [1:0] sdi_s_q;
  reg [1:0] txe_s_q;
  reg [1:0] rxe_s_q;
  reg [1:0] txk_s_q;
  reg [1:0] rxk_s_q;
  reg [9:0] bus_a_q;
  reg [9:0] bus_b_q;
  reg sck_prev_q;
  reg txk_prev_q;
  reg rxk_prev_q;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sck_s_q <= 2'h0;
      sel_s_q <= 2'h3;
      sdi_s_q <= 2'h0;
      txe_s_q <= 2'h0;
      rxe_s_q <= 2'h0;
      txk_s_q <= 2'h0;
      rxk_s_q <= 2'h0;
      bus_a_q <= 10'h000;
      bus_b_q <= 10'h000;
      sck_prev_q <= 1'b0;
      txk_prev_q <= 1'b0;
      rxk_prev_q <= 1'b0;
    end else begin
      sck_s_q <= {sck_s_q[0], serial_clock_in};
      sel_s_q <= {sel_s_q[0], serial_select_n_in};
      sdi_s_q <= {sdi_s_q[0], serial_data_io_in};
      txe_s_q <= {txe_s_q[0], tx_enable_in};
      rxe_s_q <= {rxe_s_q[0], rx_enable_in};
      txk_s_q <= {txk_s_q[0], tx_clock_in};
      rxk_s_q <= {rxk_s_q[0], rx_clock_in};
      bus_a_q <= shared_sample_bus_in;
      bus_b_q <= bus_a_q;
      sck_prev_q <= sck_s_q[1];
      txk_prev_q <= txk_s_q[1];
      rxk_prev_q <= rxk_s_q[1];
    end
  end
  wire sck = sck_s_q[1];
  wire sel_n = sel_s_q[1];
  wire sck_rise = sck && !sck_prev_q; // RULE_08
  wire sck_fall = !sck && sck_prev_q; // RULE_08
  wire txk_rise = txk_s_q[1] && !txk_prev_q;
  wire txk_fall = !txk_s_q[1] && txk_prev_q;
  wire rxk_rise = rxk_s_q[1] && !rxk_prev_q;
  wire rxk_fall = !rxk_s_q[1] && rxk_prev_q;

  // register file
  reg [7:0] cfg_q;
  reg [7:0] pwr_q;
  reg [7:0] spare_q;
  reg [7:0] clk_q;
  reg [7:0] rxf_q;
  reg [7:0] tune_q;
  reg [7:0] gain_q;
  reg [7:0] txc_q;
  reg [7:0] rxc_q;
  wire lsb_first = cfg_q[`CFG_LSBFIRST]; // RULE_11
  wire four_wire = cfg_q[`CFG_FOURWIRE]; // RULE_23

  function [7:0] reg_read;
    input [4:0] a;
    begin
      case (a) // RULE_01
        `REG_CFG: reg_read = cfg_q;
        `REG_PWR: reg_read = pwr_q;
        `REG_SPARE: reg_read = spare_q;
        `REG_CLK: reg_read = clk_q;
        `REG_RXF: reg_read = rxf_q;
        `REG_TUNE: reg_read = tune_q;
        `REG_GAIN: reg_read = gain_q;
        `REG_TXC: reg_read = txc_q;
        `REG_RXC: reg_read = rxc_q;
        `REG_VER: reg_read = {4'h0, VERSION};
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  // read byte arranged so that the shifter always sends its top bit first
  function [7:0] ordered_read;
    input [4:0] a;
    reg [7:0] v;
    begin
      v = reg_read(a);
      ordered_read = lsb_first ? rev8(v) : v; // RULE_13
    end
  endfunction

  // serial engine
  reg [1:0] st_q;
  reg [2:0] bit_q;
  reg [7:0] shift_q;
  reg rd_q;
  reg [1:0] left_q;
  reg [4:0] addr_q;
  reg [7:0] tx_sh_q;
  // next read byte, moved into the shifter at the falling edge after a byte ends
  reg [7:0] pend_q;
  reg wr_en_q;
  reg [4:0] wr_addr_q;
  reg [7:0] wr_data_q;
  wire [7:0] got = {shift_q[6:0], sdi_s_q[1]};
  wire [7:0] byte_in = lsb_first ? rev8(got) : got; // RULE_13
  wire [4:0] next_addr = lsb_first ? addr_q + 5'h01 : addr_q - 5'h01; // RULE_12 RULE_13
  wire byte_end = sck_rise && (bit_q == `BIT_LAST);

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_q <= ST_INS;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      rd_q <= 1'b0;
      left_q <= 2'h0;
      addr_q <= 5'h00;
      tx_sh_q <= 8'h00;
      pend_q <= 8'h00;
      wr_en_q <= 1'b0;
      wr_addr_q <= 5'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_en_q <= 1'b0;
      if (sel_n) begin
        st_q <= ST_INS; // RULE_09 RULE_24
        bit_q <= 3'h0;
      end else if (sck_rise) begin
        shift_q <= got;
        bit_q <= bit_q + 3'h1;
        // byte boundary: act at once, the host may deselect soon after
        if (byte_end) begin
          case (st_q)
            ST_INS: begin // RULE_03 RULE_10
              rd_q <= byte_in[`INS_READ]; // RULE_05
              left_q <= byte_in[`INS_CNT_HI:`INS_CNT_LO]; // RULE_06
              addr_q <= byte_in[`INS_ADDR_HI:`INS_ADDR_LO]; // RULE_07
              st_q <= ST_DATA; // RULE_02
              // parked until the falling edge; read data never moves while sclk is high
              pend_q <= ordered_read(byte_in[`INS_ADDR_HI:`INS_ADDR_LO]); // RULE_08
            end
            ST_DATA: begin
              if (!rd_q) begin
                wr_en_q <= 1'b1; // RULE_04
                wr_addr_q <= addr_q;
                wr_data_q <= byte_in;
              end
              addr_q <= next_addr;
              pend_q <= ordered_read(next_addr); // RULE_12 RULE_13
              if (left_q == 2'h0) begin
                st_q <= ST_DONE; // RULE_02
              end
              left_q <= left_q - 2'h1;
            end
            default: st_q <= ST_DONE;
          endcase
        end
      end else if (sck_fall && st_q == ST_DATA) begin
        if (bit_q == 3'h0) begin
          tx_sh_q <= pend_q; // RULE_08
        end else begin
          tx_sh_q <= {tx_sh_q[6:0], 1'b0}; // RULE_08
        end
      end
    end
  end

  // read data output, three-wire or four-wire
  wire reading = !sel_n && st_q == ST_DATA && rd_q;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serial_data_io_out <= 1'b0;
      serial_data_io_oe_out <= 1'b0;
      boost_serial_out_pin_out <= 1'b0;
    end else begin
      serial_data_io_out <= tx_sh_q[7];
      serial_data_io_oe_out <= reading && !four_wire; // RULE_01 RULE_09
      boost_serial_out_pin_out <= four_wire ? tx_sh_q[7] : gain_q[6]; // RULE_23
    end
  end

  // register write; software reset keeps register zero except its reset bit
  wire sw_rst = cfg_q[`CFG_SWRESET];
  assign soft_reset_out = sw_rst;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_q <= `RST_CFG;
      pwr_q <= `RST_PWR;
      spare_q <= `RST_SPARE;
      clk_q <= `RST_CLK;
      rxf_q <= `RST_RXF;
      tune_q <= `RST_TUNE;
      gain_q <= `RST_GAIN;
      txc_q <= `RST_TXC;
      rxc_q <= `RST_RXC;
    end else if (sw_rst) begin
      cfg_q[`CFG_SWRESET] <= 1'b0;
      pwr_q <= `RST_PWR;
      spare_q <= `RST_SPARE;
      clk_q <= `RST_CLK;
      rxf_q <= `RST_RXF;
      tune_q <= `RST_TUNE;
      gain_q <= `RST_GAIN;
      txc_q <= `RST_TXC;
      rxc_q <= `RST_RXC;
    end else if (wr_en_q) begin
      case (wr_addr_q) // RULE_04
        `REG_CFG: cfg_q <= wr_data_q;
        `REG_PWR: pwr_q <= wr_data_q;
        `REG_SPARE: spare_q <= wr_data_q;
        `REG_CLK: clk_q <= wr_data_q;
        `REG_RXF: rxf_q <= wr_data_q;
        `REG_TUNE: tune_q <= wr_data_q;
        `REG_GAIN: gain_q <= wr_data_q;
        `REG_TXC: txc_q <= wr_data_q;
        `REG_RXC: rxc_q <= wr_data_q;
        default: cfg_q <= cfg_q;
      endcase
    end
  end
  assign pwr_reg_out = pwr_q;
  assign clk_reg_out = clk_q;
  assign rxf_reg_out = rxf_q;
  assign tune_reg_out = tune_q;
  assign gain_reg_out = gain_q;
  assign txc_reg_out = txc_q;
  assign rxc_reg_out = rxc_q;

  // transmit path: capture on selected edge into the fifo
  wire tx_edge = txc_q[`TXC_FALL] ? txk_fall : txk_rise; // RULE_20
  wire tx_take = tx_edge && txe_s_q[1] && !rxe_s_q[1]; // RULE_14 RULE_16
  // twos complement converts to straight binary by msb flip
  wire [9:0] tx_conv = fmt_flip(bus_b_q, txc_q[`TXC_TWOS]); // RULE_20
  wire fifo_in_ready;
  // no stall toward the host is possible, so a full fifo drops the word
  assign fifo_overflow_out = tx_take && !fifo_in_ready;
  sample_fifo #(
    .WIDTH(10),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_tx_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .in_data_in(tx_conv),
    .in_valid_in(tx_take),
    .in_ready_out(fifo_in_ready),
    .out_data_out(tx_word_out),
    .out_valid_out(tx_word_valid_out),
    .out_ready_in(tx_word_ready_in)
  );

  // receive clock watchdog: a parked clock releases the bus after the idle limit,
  // so a host that stops the clock never sees a stale word held on the bus
  reg [7:0] rxk_idle_q;
  wire rxk_running = (rxk_idle_q != `RXK_IDLE_LIMIT);
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rxk_idle_q <= `RXK_IDLE_LIMIT;
    end else if (rxk_rise || rxk_fall) begin
      rxk_idle_q <= 8'h00; // RULE_17
    end else if (rxk_running) begin
      rxk_idle_q <= rxk_idle_q + 8'h01;
    end
  end

  // receive path: update bus word on the edge opposite the validating one
  wire rx_upd = rxc_q[`RXC_FALL] ? rxk_rise : rxk_fall; // RULE_20
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shared_sample_bus_out <= 10'h000;
      shared_sample_bus_oe_out <= 1'b0;
    end else begin
      if (rx_upd) begin // RULE_17
        shared_sample_bus_out <= fmt_flip(rx_sample_in, rxc_q[`RXC_TWOS]); // RULE_20
      end
      // drive only while receive enabled, clock present and not three-stated
      shared_sample_bus_oe_out <= rxe_s_q[1] && rxk_running &&
                                  !rxc_q[`RXC_TRISTATE]; // RULE_17 RULE_18 RULE_21
    end
  end
endmodule // frontend_host_if

/* sim/fe_props_properties.sv */
// Purpose: pin-level checks of the front-end host interface
// Assumes: one clk_in domain, pins pass two-flop synchronisers
// Notes: windows leave room for synchroniser latency
`timescale 1ns/10ps
module fe_props (
  input wire clk_in, // clock
  input wire rstn_in, // reset
  input wire serial_clock_in, // serial clock
  input wire serial_select_n_in, // select
  input wire serial_data_io_out, // read bit
  input wire serial_data_io_oe_out, // read drive
  input wire tx_enable_in, // tx enable
  input wire rx_enable_in, // rx enable
  input wire shared_sample_bus_oe_out, // bus drive
  input wire tx_word_valid_out, // fifo head
  input wire [7:0] gain_reg_out, // gain reg
  input wire [7:0] rxc_reg_out, // rx config
  input wire soft_reset_out, // soft reset
  input wire fifo_overflow_out // dropped word
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_bus_released:
    assert property (!rx_enable_in [*5] |-> !shared_sample_bus_oe_out) else $error("bus driven");
  a_rx_driven:
    assert property ((rx_enable_in && !rxc_reg_out[3]) [*5] |-> shared_sample_bus_oe_out)
      else $error("rx bus not driven");
  a_tristate_mode:
    assert property (rxc_reg_out[3] [*3] |-> !shared_sample_bus_oe_out) else $error("not released");
  a_select_idle:
    assert property (serial_select_n_in [*5] |-> !serial_data_io_oe_out) else $error("idle drive");
  a_read_on_fall:
    assert property ($past(serial_data_io_oe_out, 2) && serial_data_io_oe_out
      && $changed(serial_data_io_out) |-> !serial_clock_in) else $error("read bit moved early");
  a_write_gated:
    assert property ($changed(gain_reg_out) && !soft_reset_out && !$past(soft_reset_out)
      |-> !$past(serial_select_n_in, 4)) else $error("write without select");
  a_ovf_full:
    assert property (fifo_overflow_out |-> tx_word_valid_out) else $error("overflow when empty");
  a_tx_gated:
    assert property ((!tx_enable_in || rx_enable_in) [*8]
      |-> !fifo_overflow_out && !$rose(tx_word_valid_out)) else $error("word taken, tx off");
endmodule // fe_props

bind frontend_host_if fe_props u_props (.clk_in, .rstn_in, .serial_clock_in, .serial_select_n_in,
  .serial_data_io_out, .serial_data_io_oe_out, .tx_enable_in, .rx_enable_in,
  .shared_sample_bus_oe_out, .tx_word_valid_out, .gain_reg_out, .rxc_reg_out,
  .soft_reset_out, .fifo_overflow_out);

/* sim/host_model.sv */
// Purpose: baseband host on the three-wire register port
// Assumes: serial clock idles low and runs only inside frames
// Notes: data line released in reads; the bench resolves the wire
`timescale 1ns/10ps
module host_model (
  input wire clk_in, // frame pacing
  input wire miso_in, // resolved data line
  input wire boost_in, // four-wire output
  output logic sclk_out, // serial clock
  output logic sel_n_out, // select, active low
  output logic mosi_out, // data drive value
  output logic mosi_oe_out // data drive enable
);
  logic lsb = 0, fw = 0; // bit order and four-wire, set by bench
  logic [7:0] dat [4];
  initial begin
    sclk_out = 0;
    sel_n_out = 1;
    mosi_out = 0;
    mosi_oe_out = 0;
  end
  // 62.5 ns halves keep the clock well under 25 mhz
  task automatic shift(input logic [7:0] v, input int nb, output logic [7:0] r);
    r = 0;
    for (int i = 0; i < nb; i++) begin
      mosi_out = lsb ? v[i] : v[7-i];
      #62.5 sclk_out = 1;
      r[lsb ? i : 7-i] = fw ? boost_in : miso_in;
      // bit held until the falling edge: the device samples a few clocks late
      #62.5 sclk_out = 0;
    end
  endtask
  task automatic xfer(input logic rd, input logic [1:0] n, input logic [4:0] a, input int ab);
    logic [7:0] r;
    #250 @(posedge clk_in);
    #1 sel_n_out = 0;
    mosi_oe_out = 1;
    shift({rd, n, a}, 8, r);
    mosi_oe_out = !rd;
    for (int k = 0; k <= n; k++) begin
      shift(dat[k], ab ? ab : 8, r);
      if (rd) dat[k] = r;
      if (ab) break;
    end
    #62.5 sel_n_out = 1;
    mosi_oe_out = 0;
  endtask
endmodule // host_model

/* sim/frontend_host_if_test.sv */
// Purpose: self-checking bench for the front-end host interface
// Assumes: host_model drives the serial port, bench the sample pins
// Notes: data line pulled up; an undriven sample bus reads all ones
`timescale 1ns/10ps
module frontend_host_if_test;
  logic clk_in = 0, rstn_in = 0, tx_enable_in = 0, rx_enable_in = 0;
  logic tx_clock_in = 0, tx_word_ready_in = 0;
  logic [9:0] tx_bus = 0, rx_sample_in = 10'h2c5;
  wire serial_clock_in, serial_select_n_in, serial_data_io_in, rx_clock_in, mosi, mosi_oe;
  wire serial_data_io_out, serial_data_io_oe_out, boost_serial_out_pin_out;
  wire shared_sample_bus_oe_out, tx_word_valid_out, soft_reset_out, fifo_overflow_out;
  wire [9:0] shared_sample_bus_in, shared_sample_bus_out, tx_word_out;
  wire [7:0] pwr_reg_out, clk_reg_out, rxf_reg_out, tune_reg_out;
  wire [7:0] gain_reg_out, txc_reg_out, rxc_reg_out;
  int err_count = 0, num_checks = 0, cycles = 0, ovf = 0, srst = 0;
  assign serial_data_io_in = serial_data_io_oe_out ? serial_data_io_out : mosi_oe ? mosi : 1'b1;
  assign shared_sample_bus_in = shared_sample_bus_oe_out ? shared_sample_bus_out
    : tx_enable_in ? tx_bus : 10'h3ff;
  assign rx_clock_in = ~tx_clock_in;
  always #4 clk_in = ~clk_in;
  always #62.5 tx_clock_in = ~tx_clock_in;
  frontend_host_if #(.VERSION(4'h9)) DUT (.*); // version value arbitrary
  host_model host (.clk_in, .miso_in(serial_data_io_in), .boost_in(boost_serial_out_pin_out),
    .sclk_out(serial_clock_in), .sel_n_out(serial_select_n_in), .mosi_out(mosi),
    .mosi_oe_out(mosi_oe));
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task wr1(input logic [4:0] a, input logic [7:0] v);
    host.dat[0] = v;
    host.xfer(0, 0, a, 0);
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (fifo_overflow_out === 1'b1) ovf <= ovf + 1;
    if (soft_reset_out === 1'b1) srst <= srst + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge clk_in);
    #1 rstn_in = 1;
    repeat (4) @(posedge clk_in);
    chk("defaults", 56'h00010180001000, {pwr_reg_out, clk_reg_out, rxf_reg_out,
      tune_reg_out, gain_reg_out, txc_reg_out, rxc_reg_out});
    host.dat[0] = 8'h5a;
    host.xfer(0, 0, 5'h06, 6);
    chk("gain after abort", 0, gain_reg_out);
    host.dat[0] = 8'h11;
    host.dat[1] = 8'h2a;
    host.xfer(0, 1, 5'h07, 0);
    chk("txc gain", 16'h112a, {txc_reg_out, gain_reg_out});
    host.xfer(1, 2, 5'h08, 0);
    chk("read 08 down", 24'h00112a, {host.dat[0], host.dat[1], host.dat[2]});
    host.xfer(1, 1, 5'h0f, 0);
    chk("version", 16'h0900, {host.dat[0], host.dat[1]});
    wr1(5'h00, 8'h40);
    host.lsb = 1;
    host.dat[0] = 8'h33;
    host.dat[1] = 8'h9c;
    host.xfer(0, 1, 5'h04, 0);
    chk("rxf tune", 16'h339c, {rxf_reg_out, tune_reg_out});
    host.xfer(1, 1, 5'h04, 0);
    chk("lsb read", 16'h339c, {host.dat[0], host.dat[1]});
    wr1(5'h00, 8'hc0);
    host.fw = 1;
    host.xfer(1, 0, 5'h06, 0);
    chk("four-wire read", 8'h2a, host.dat[0]);
    wr1(5'h00, 8'h00);
    host.lsb = 0;
    host.fw = 0;
    // fifo fills with ready held low; two words must drop
    @(negedge tx_clock_in);
    #1 tx_enable_in = 1;
    for (int i = 0; i < 34; i++) begin
      tx_bus = 10'(i * 29);
      @(negedge tx_clock_in);
      #1;
    end
    tx_enable_in = 0;
    repeat (50) @(posedge clk_in);
    chk("overflows", 2, ovf);
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_in);
      #1 chk("tx word", {1'b1, 10'(i * 29) ^ 10'h200}, {tx_word_valid_out, tx_word_out});
      tx_word_ready_in = 1;
      @(posedge clk_in);
      #1 tx_word_ready_in = 0;
    end
    repeat (3) @(posedge clk_in);
    chk("fifo empty", 0, tx_word_valid_out);
    #1 rx_enable_in = 1;
    repeat (40) @(posedge clk_in);
    chk("rx drive", {1'b1, 10'h2c5}, {shared_sample_bus_oe_out, shared_sample_bus_out});
    wr1(5'h08, 8'h09);
    chk("three-state", 0, shared_sample_bus_oe_out);
    wr1(5'h08, 8'h01);
    repeat (40) @(posedge clk_in);
    chk("rx twos", {1'b1, 10'h0c5}, {shared_sample_bus_oe_out, shared_sample_bus_out});
    #1 rx_enable_in = 0;
    repeat (8) @(posedge clk_in);
    chk("released", 0, shared_sample_bus_oe_out);
    // software reset: all but register zero back to defaults, reset bit self-clears
    wr1(5'h00, 8'h20);
    chk("soft reset regs", 56'h00010180001000, {pwr_reg_out, clk_reg_out, rxf_reg_out,
      tune_reg_out, gain_reg_out, txc_reg_out, rxc_reg_out});
    chk("soft reset pulses", 1, srst);
    host.xfer(1, 0, 5'h00, 0);
    chk("cfg after soft reset", 0, host.dat[0]);
    report_and_stop();
  end
endmodule // frontend_host_if_test
